/* mcio_top.sv */
// mcio_top: switch debounce, duty drivers, on/off outputs, pot scaling and analog inputs
// assumes: adc codes and the proportional driver duty come from logic on clk_i;
// switch and sense pins are asynchronous and are synchronised here
`timescale 1ns/1ps

// Overview of operation
// - sixteen inputs: nine switches plus seven output sense lines
// - debounce time is code times 4 ms, from 0 to 32 ms
// - debounce defaults to 16 ms until software changes it
// - five duty drivers and two plain on/off outputs
// - duty 0 to 32767 maps linearly onto 0 to 100 percent on-time
// - automatic mode refreshes the duty of drivers one to four from a bound source
// - each driver has a readable copy of its applied duty
// - fifth driver takes written duty only while proportional drive is off
// - on/off outputs have set and clear commands and a readable state
// - all outputs are active low: on pulls the pin to ground
// - pot inputs scale per three-wire, two-wire or one-wire wiring
// - pot position 0 to 100 percent reads as 0 to 32736, the code times 32
// - wiring setting applies only when the input type is 5
// - type 5 takes the chain input from a software command instead
// - pot faults beyond high or low thresholds, types 1 to 5
// - a pot fault forces the reported value to a substitute level
// - both analog inputs sampled every millisecond, 0 to 1023
// - filtered analog values with programmable cutoff, default code 328
// - analog pins also act as switch inputs one and two
// - analog output is duty channel six, readable
module mcio_top #(
  parameter int TICK_CYCLES = mcio_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // switch and sense pins
  input wire logic [6:0] switch_input_i,
  input wire logic [6:0] output_sense_i,
  // adc codes
  input wire logic [9:0] analog_code_i [2],
  input wire logic [9:0] pot_wiper_i [2],
  input wire logic [9:0] pot_low_i [2],
  // proportional driver duty
  input wire logic [14:0] pd_duty_i,
  // output pins, active low
  output logic [4:0] driver_output_n_o,
  output logic [1:0] onoff_output_n_o,
  output logic analog_output_n_o,
  // signal chain commands
  output logic [15:0] drive_chain_o,
  output logic [15:0] stop_chain_o
);

  // =====================================================================
  // millisecond enable
  logic [16:0] tick_cnt_reg;
  wire tick_ms = tick_cnt_reg == 17'(TICK_CYCLES - 1);

  // free-running millisecond divider
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) tick_cnt_reg <= 17'h00000;
    else tick_cnt_reg <= tick_ms ? 17'h00000 : tick_cnt_reg + 17'h00001;
  end

  // =====================================================================
  // register write decode
  logic [3:0] dbn_code_reg;
  logic [14:0] duty_reg [6];
  logic [11:0] auto_sel_reg;
  logic pd_en_reg;
  logic [1:0] onoff_reg;
  logic [13:0] pot_cfg_reg;
  logic [15:0] pot_hi_reg [2];
  logic [15:0] pot_lo_reg [2];
  logic [15:0] pot_sub_reg [2];
  logic [15:0] soft_cmd_reg [2];
  logic [15:0] cutoff_reg [2];

  wire wr_dbn = reg_wr_i && reg_addr_i == mcio_pkg::REG_DBN_CFG;
  wire wr_auto = reg_wr_i && reg_addr_i == mcio_pkg::REG_AUTO_SEL;
  wire wr_pd = reg_wr_i && reg_addr_i == mcio_pkg::REG_PD_EN;
  wire wr_set = reg_wr_i && reg_addr_i == mcio_pkg::REG_ONOFF_SET;
  wire wr_clr = reg_wr_i && reg_addr_i == mcio_pkg::REG_ONOFF_CLR;
  wire wr_pot_cfg = reg_wr_i && reg_addr_i == mcio_pkg::REG_POT_CFG;
  // negative codes become zero
  wire [14:0] wdata_clamped = reg_wdata_i[15] ? 15'h0000 : reg_wdata_i[14:0];
  wire [3:0] dbn_code_wr = (reg_wdata_i[3:0] > mcio_pkg::DBN_CODE_MAX) ?
                           mcio_pkg::DBN_CODE_MAX : reg_wdata_i[3:0];

  // single-register controls
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dbn_code_reg <= mcio_pkg::DBN_CODE_RST;
      auto_sel_reg <= 12'h000;
      pd_en_reg <= 1'b0;
      onoff_reg <= 2'h0;
      pot_cfg_reg <= 14'h0000;
    end else begin
      if (wr_dbn) dbn_code_reg <= dbn_code_wr;
      if (wr_auto) auto_sel_reg <= reg_wdata_i[11:0];
      if (wr_pd) pd_en_reg <= reg_wdata_i[0];
      if (wr_pot_cfg) pot_cfg_reg <= reg_wdata_i[13:0];
      if (wr_set) onoff_reg <= onoff_reg | reg_wdata_i[1:0];
      else if (wr_clr) onoff_reg <= onoff_reg & ~reg_wdata_i[1:0];
    end
  end

  // =====================================================================
  // duty channels: write, source select, readback and waveform
  logic [14:0] pwm_cnt_reg;
  logic [14:0] applied_duty [6];
  logic [5:0] pwm_on;
  logic [14:0] pot_val [2];
  logic [9:0] ana_smooth [2];

  // shared period counter; full code is always on
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) pwm_cnt_reg <= 15'h0000;
    else if (pwm_cnt_reg == 15'(mcio_pkg::PWM_PERIOD - 1)) pwm_cnt_reg <= 15'h0000;
    else pwm_cnt_reg <= pwm_cnt_reg + 15'h0001;
  end

  genvar gc;
  generate
    for (gc = 0; gc < 6; gc++) begin : g_duty
      logic [14:0] applied_reg;
      logic on_reg;
      wire wr_duty = reg_wr_i && reg_addr_i == 8'(mcio_pkg::REG_DUTY0 + gc);
      wire [1:0] src = (gc < 4) ? auto_sel_reg[2 * gc +: 2] : 2'h0;
      wire [14:0] src_val = (src == 2'h1) ? pot_val[0] :
                            (src == 2'h2) ? pot_val[1] :
                            {ana_smooth[0], 5'h00};
      // automatic binding refreshes the duty every cycle
      wire [14:0] sel_duty = (src == 2'h0) ? duty_reg[gc] : src_val;
      // fifth driver follows the proportional driver
      wire [14:0] fin_duty = (gc == 4 && pd_en_reg) ? pd_duty_i : sel_duty;

      // written duty code
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) duty_reg[gc] <= 15'h0000;
        else if (wr_duty) duty_reg[gc] <= wdata_clamped;
      end

      // applied duty and waveform
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          applied_reg <= 15'h0000;
          on_reg <= 1'b0;
        end else begin
          applied_reg <= fin_duty;
          on_reg <= pwm_cnt_reg < applied_reg;
        end
      end

      assign applied_duty[gc] = applied_reg;
      assign pwm_on[gc] = on_reg;
    end
  endgenerate

  // pins pull low while on
  assign driver_output_n_o = ~pwm_on[4:0];
  assign analog_output_n_o = ~pwm_on[5];
  assign onoff_output_n_o = ~onoff_reg;

  // =====================================================================
  // per-pot settings
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_potcfg
      wire wr_hi = reg_wr_i && reg_addr_i == 8'(mcio_pkg::REG_POT_HI0 + gp);
      wire wr_lo = reg_wr_i && reg_addr_i == 8'(mcio_pkg::REG_POT_LO0 + gp);
      wire wr_sub = reg_wr_i && reg_addr_i == 8'(mcio_pkg::REG_POT_SUB0 + gp);
      wire wr_soft = reg_wr_i && reg_addr_i == 8'(mcio_pkg::REG_SOFT_DRIVE + gp);
      wire wr_cut = reg_wr_i && reg_addr_i == 8'(mcio_pkg::REG_ANA_CUTOFF0 + gp);

      // per-pot settings
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pot_hi_reg[gp] <= mcio_pkg::POT_HI_RST;
          pot_lo_reg[gp] <= mcio_pkg::POT_LO_RST;
          pot_sub_reg[gp] <= mcio_pkg::POT_SUB_RST;
          soft_cmd_reg[gp] <= 16'h0000;
          cutoff_reg[gp] <= mcio_pkg::CUTOFF_RST;
        end else begin
          if (wr_hi) pot_hi_reg[gp] <= reg_wdata_i;
          if (wr_lo) pot_lo_reg[gp] <= reg_wdata_i;
          if (wr_sub) pot_sub_reg[gp] <= {1'b0, wdata_clamped};
          if (wr_soft) soft_cmd_reg[gp] <= reg_wdata_i;
          if (wr_cut) cutoff_reg[gp] <= {1'b0, wdata_clamped};
        end
      end
    end
  endgenerate

  // =====================================================================
  // pot scaling, fault detection and chain selection
  logic [1:0] pot_fault;
  logic [15:0] chain_cmd [2];

  generate
    for (gp = 0; gp < 2; gp++) begin : g_pot
      logic [14:0] val_reg;
      logic fault_reg;
      wire [2:0] ptype = pot_cfg_reg[mcio_pkg::POT_TYPE_POS + 3 * gp +: 3];
      wire [1:0] wire_cfg = pot_cfg_reg[mcio_pkg::POT_WIRE_POS + 2 * gp +: 2];
      // wiring setting counts only for type 5
      wire [1:0] wiring = (ptype == mcio_pkg::POT_TYPE_SOFT) ? wire_cfg :
                          (ptype == mcio_pkg::POT_TYPE_RHEO) ? 2'(mcio_pkg::MCIO_TWO_WIRE) :
                          2'(mcio_pkg::MCIO_THREE_WIRE);
      wire three = wiring == 2'(mcio_pkg::MCIO_THREE_WIRE);
      wire [9:0] span = pot_wiper_i[gp] > pot_low_i[gp] ?
                        pot_wiper_i[gp] - pot_low_i[gp] : 10'h000;
      // three-wire removes the low reference
      wire [9:0] pos = three ? span : pot_wiper_i[gp];
      wire [14:0] scaled = {pos, 5'h00};
      wire [15:0] wiper16 = {6'h00, pot_wiper_i[gp]};
      wire detect = ptype != 3'h0 && ptype <= mcio_pkg::POT_TYPE_SOFT;
      wire fault = detect && (wiper16 > pot_hi_reg[gp] || wiper16 < pot_lo_reg[gp]);

      // position, or the substitute on a fault
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          val_reg <= 15'h0000;
          fault_reg <= 1'b0;
        end else begin
          fault_reg <= fault;
          val_reg <= fault ? pot_sub_reg[gp][14:0] : scaled;
        end
      end

      assign pot_val[gp] = val_reg;
      assign pot_fault[gp] = fault_reg;
      // type 5 feeds the chain from software
      assign chain_cmd[gp] = (ptype == mcio_pkg::POT_TYPE_SOFT) ?
                             soft_cmd_reg[gp] : {1'b0, val_reg};
    end
  endgenerate

  assign drive_chain_o = chain_cmd[0];
  assign stop_chain_o = chain_cmd[1];

  // =====================================================================
  // analog sampling and smoothing
  logic [9:0] ana_sample [2];

  generate
    for (gp = 0; gp < 2; gp++) begin : g_ana
      logic [9:0] sample_reg;
      logic [25:0] filt_reg;
      wire [16:0] gain_raw = 17'((cutoff_reg[gp] * mcio_pkg::FILT_GAIN_NUM)
                                 >> mcio_pkg::FILT_GAIN_SHIFT);
      wire [16:0] gain = gain_raw[16] ? 17'h0FFFF : gain_raw;
      wire signed [26:0] diff = $signed({1'b0, sample_reg, 16'h0000}) -
                                $signed({1'b0, filt_reg});
      wire signed [44:0] prod = diff * $signed({1'b0, gain});
      wire signed [26:0] step = 27'(prod >>> 16);
      wire [26:0] next_sum = 27'($signed({1'b0, filt_reg}) + step);

      // sample and filter once per millisecond
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sample_reg <= 10'h000;
          filt_reg <= 26'h0000000;
        end else if (tick_ms) begin
          sample_reg <= analog_code_i[gp];
          filt_reg <= next_sum[25:0];
        end
      end

      assign ana_sample[gp] = sample_reg;
      assign ana_smooth[gp] = filt_reg[25:16];
    end
  endgenerate

  // =====================================================================
  // switch inputs
  logic [6:0] sw_meta_reg, sw_sync_reg;
  logic [6:0] sense_meta_reg, sense_sync_reg;

  // two-stage synchronisers for the asynchronous pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_meta_reg <= 7'h00;
      sw_sync_reg <= 7'h00;
      sense_meta_reg <= 7'h00;
      sense_sync_reg <= 7'h00;
    end else begin
      sw_meta_reg <= switch_input_i;
      sw_sync_reg <= sw_meta_reg;
      sense_meta_reg <= output_sense_i;
      sense_sync_reg <= sense_meta_reg;
    end
  end

  mcio_dbn_if dbn ();
  assign dbn.tick = tick_ms;
  assign dbn.limit_ms = 6'(dbn_code_reg * mcio_pkg::DBN_STEP_MS);
  // order: analog pins, dedicated switches 3..8, sense lines, switch 16
  assign dbn.raw = {sw_sync_reg[6], sense_sync_reg, sw_sync_reg[5:0],
                    ana_sample[1] >= mcio_pkg::ANA_SW_LEVEL,
                    ana_sample[0] >= mcio_pkg::ANA_SW_LEVEL};

  mcio_debounce u_debounce (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .dbn(dbn.bank)
  );

  // =====================================================================
  // register read
  logic [15:0] rdata_next;
  wire [7:0] a = reg_addr_i;

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 16'h0000;
    if (a == mcio_pkg::REG_SW_STATE) rdata_next = dbn.state;
    else if (a == mcio_pkg::REG_DBN_CFG) rdata_next = {12'h000, dbn_code_reg};
    else if (a >= mcio_pkg::REG_DUTY0 && a < mcio_pkg::REG_DUTY0 + 8'h06)
      rdata_next = {1'b0, duty_reg[3'(a - mcio_pkg::REG_DUTY0)]};
    else if (a >= mcio_pkg::REG_DUTY_RB0 && a < mcio_pkg::REG_DUTY_RB0 + 8'h06)
      rdata_next = {1'b0, applied_duty[3'(a - mcio_pkg::REG_DUTY_RB0)]};
    else if (a == mcio_pkg::REG_AUTO_SEL) rdata_next = {4'h0, auto_sel_reg};
    else if (a == mcio_pkg::REG_PD_EN) rdata_next = {15'h0000, pd_en_reg};
    else if (a == mcio_pkg::REG_ONOFF_SET) rdata_next = {14'h0000, onoff_reg};
    else if (a == mcio_pkg::REG_POT_CFG) rdata_next = {2'h0, pot_cfg_reg};
    else if (a == mcio_pkg::REG_POT_HI0 || a == mcio_pkg::REG_POT_HI0 + 8'h01)
      rdata_next = pot_hi_reg[a[0] ^ mcio_pkg::REG_POT_HI0[0]];
    else if (a == mcio_pkg::REG_POT_LO0 || a == mcio_pkg::REG_POT_LO0 + 8'h01)
      rdata_next = pot_lo_reg[a[0] ^ mcio_pkg::REG_POT_LO0[0]];
    else if (a == mcio_pkg::REG_POT_SUB0 || a == mcio_pkg::REG_POT_SUB0 + 8'h01)
      rdata_next = pot_sub_reg[a[0] ^ mcio_pkg::REG_POT_SUB0[0]];
    else if (a == mcio_pkg::REG_SOFT_DRIVE || a == mcio_pkg::REG_SOFT_STOP)
      rdata_next = soft_cmd_reg[a[0] ^ mcio_pkg::REG_SOFT_DRIVE[0]];
    else if (a == mcio_pkg::REG_POT_VAL0 || a == mcio_pkg::REG_POT_VAL0 + 8'h01)
      rdata_next = {1'b0, pot_val[a[0] ^ mcio_pkg::REG_POT_VAL0[0]]};
    else if (a == mcio_pkg::REG_CHAIN0 || a == mcio_pkg::REG_CHAIN0 + 8'h01)
      rdata_next = chain_cmd[a[0] ^ mcio_pkg::REG_CHAIN0[0]];
    else if (a == mcio_pkg::REG_POT_FAULT) rdata_next = {14'h0000, pot_fault};
    else if (a[7:1] == mcio_pkg::REG_ANA_SAMPLE0[7:1])
      rdata_next = {6'h00, ana_sample[a[0]]};
    else if (a[7:1] == mcio_pkg::REG_ANA_SMOOTH0[7:1])
      rdata_next = {6'h00, ana_smooth[a[0]]};
    else if (a[7:1] == mcio_pkg::REG_ANA_CUTOFF0[7:1])
      rdata_next = cutoff_reg[a[0]];
  end

  // read data stands one cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) reg_rdata_o <= 16'h0000;
    else reg_rdata_o <= reg_rd_i ? rdata_next : 16'h0000;
  end

endmodule

/* mcio_pkg.sv */
// mcio_pkg: register map, reset values and timing constants
// assumes: a 125 MHz system clock and a 16-bit register port
package mcio_pkg;

  // =====================================================================
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int DBN_STEP_MS = 4;
  localparam int DBN_MAX_MS = 32;
  localparam logic [3:0] DBN_CODE_MAX = 4'(DBN_MAX_MS / DBN_STEP_MS);
  localparam logic [3:0] DBN_CODE_RST = 4'h4;
  localparam int PWM_PERIOD = 32767;

  // =====================================================================
  // value ranges and defaults
  localparam logic [14:0] DUTY_MAX = 15'h7FFF;
  localparam logic [15:0] CUTOFF_RST = 16'h0148;
  localparam logic [9:0] ANA_SW_LEVEL = 10'h200;
  localparam logic [15:0] POT_HI_RST = 16'h03E0;
  localparam logic [15:0] POT_LO_RST = 16'h0010;
  localparam logic [15:0] POT_SUB_RST = 16'h0000;
  localparam int FILT_GAIN_NUM = 25;
  localparam int FILT_GAIN_SHIFT = 1;

  // =====================================================================
  // potentiometer wiring and type codes
  typedef enum logic [1:0] {MCIO_THREE_WIRE, MCIO_TWO_WIRE, MCIO_ONE_WIRE} mcio_wiring_t;
  localparam logic [2:0] POT_TYPE_SOFT = 3'h5;
  localparam logic [2:0] POT_TYPE_RHEO = 3'h1;

  // =====================================================================
  // register offsets
  localparam logic [7:0] REG_SW_STATE = 8'h00;
  localparam logic [7:0] REG_DBN_CFG = 8'h01;
  localparam logic [7:0] REG_DUTY0 = 8'h02;
  localparam logic [7:0] REG_DUTY_RB0 = 8'h08;
  localparam logic [7:0] REG_AUTO_SEL = 8'h0E;
  localparam logic [7:0] REG_PD_EN = 8'h0F;
  localparam logic [7:0] REG_ONOFF_SET = 8'h10;
  localparam logic [7:0] REG_ONOFF_CLR = 8'h11;
  localparam logic [7:0] REG_POT_CFG = 8'h12;
  localparam logic [7:0] REG_POT_HI0 = 8'h13;
  localparam logic [7:0] REG_POT_LO0 = 8'h15;
  localparam logic [7:0] REG_POT_SUB0 = 8'h17;
  localparam logic [7:0] REG_SOFT_DRIVE = 8'h19;
  localparam logic [7:0] REG_SOFT_STOP = 8'h1A;
  localparam logic [7:0] REG_POT_VAL0 = 8'h1B;
  localparam logic [7:0] REG_CHAIN0 = 8'h1D;
  localparam logic [7:0] REG_POT_FAULT = 8'h1F;
  localparam logic [7:0] REG_ANA_SAMPLE0 = 8'h20;
  localparam logic [7:0] REG_ANA_SMOOTH0 = 8'h22;
  localparam logic [7:0] REG_ANA_CUTOFF0 = 8'h24;

  // field positions of the pot configuration register
  localparam int POT_WIRE_POS = 0;
  localparam int POT_TYPE_POS = 4;

endpackage

/* mcio_dbn_if.sv */
// mcio_dbn_if: raw switch levels, debounce limit and debounced states
// assumes: one clock; tick is a one-cycle millisecond enable
`timescale 1ns/1ps
interface mcio_dbn_if;
  logic tick;
  logic [5:0] limit_ms;
  logic [15:0] raw;
  logic [15:0] state;
  modport ctl (output tick, output limit_ms, output raw, input state);
  modport bank (input tick, input limit_ms, input raw, output state);
endinterface

/* mcio_debounce.sv */
// mcio_debounce: one debounce filter per switch input
// assumes: raw levels synchronised to clk_i
`timescale 1ns/1ps
module mcio_debounce (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // switch group
  mcio_dbn_if.bank dbn
);

  // =====================================================================
  // per-input filters
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_sw
      logic [5:0] cnt_reg;
      logic state_reg;
      wire differs = dbn.raw[gi] != state_reg;
      wire held = (cnt_reg + 6'h01) >= dbn.limit_ms;

      // count held milliseconds
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_reg <= 6'h00;
          state_reg <= 1'b0;
        end else if (dbn.limit_ms == 6'h00) begin
          cnt_reg <= 6'h00;
          state_reg <= dbn.raw[gi];
        end else if (!differs) begin
          cnt_reg <= 6'h00;
        end else if (dbn.tick) begin
          if (held) begin
            state_reg <= dbn.raw[gi];
            cnt_reg <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
      end

      assign dbn.state[gi] = state_reg;
    end
  endgenerate

endmodule

/* mcio_top_monitor.sv */
// mcio_top_monitor: port-level timing checks of mcio_top
// assumes: bound into every mcio_top; one clock, async active-low reset
`timescale 1ns/1ps
module mcio_top_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // output pins
  input wire logic [4:0] driver_output_n_o,
  input wire logic [1:0] onoff_output_n_o,
  input wire logic analog_output_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ===================================================================
  // register port and output pins
  AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i == 8'hFF |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_RESET_OFF: assert property ($rose(resetn_i) |->
    &driver_output_n_o && &onoff_output_n_o && analog_output_n_o)
    else $error("outputs on after reset");
  AST_AOUT_FULL: assert property (reg_wr_i && reg_addr_i == 8'h07 && reg_wdata_i == 16'h7FFF
    |-> ##[1:4] !analog_output_n_o)
    else $error("full duty not on");
  AST_AOUT_ZERO: assert property (reg_wr_i && reg_addr_i == 8'h07 && reg_wdata_i[15]
    |-> ##4 analog_output_n_o [*8])
    else $error("clamped duty not off");
  AST_ONOFF_SET: assert property (reg_wr_i && reg_addr_i == 8'h10 && reg_wdata_i[0]
    |-> ##[1:2] !onoff_output_n_o[0])
    else $error("set did not pull output low");
  AST_ONOFF_CLR: assert property (reg_wr_i && reg_addr_i == 8'h11 && reg_wdata_i[1]
    |-> ##[1:2] onoff_output_n_o[1])
    else $error("clear did not release output");
  AST_ONOFF_HOLD: assert property ($changed(onoff_output_n_o)
    |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("on/off output changed unasked");
endmodule

bind mcio_top mcio_top_monitor i_mcio_top_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .driver_output_n_o(driver_output_n_o),
  .onoff_output_n_o(onoff_output_n_o), .analog_output_n_o(analog_output_n_o));

/* mcio_field_model.sv */
// mcio_field_model: switches and coils at the pins of mcio_top
// assumes: a coil pulls its sense line high while the output is off
`timescale 1ns/1ps
module mcio_field_model (
  // bench side
  input wire logic [6:0] sw_level_i,
  // output pins of the block
  input wire logic [4:0] driver_n_i,
  input wire logic [1:0] onoff_n_i,
  // input pins of the block
  output logic [6:0] switch_o,
  output logic [6:0] sense_o
);
  // each sense line shows the pin its coil hangs on
  assign switch_o = sw_level_i;
  assign sense_o = {onoff_n_i, driver_n_i};
endmodule

/* mcio_top_tb.sv */
// mcio_top_tb: directed tests of mcio_top
// assumes: package and design compiled first
`timescale 1ns/1ps
module mcio_top_tb;
  localparam int T = 20;
  logic clk_i, resetn_i, reg_wr_i, reg_rd_i, analog_output_n_o;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, drive_chain_o, stop_chain_o, v;
  logic [6:0] switch_input_i, output_sense_i, sw_level;
  logic [9:0] analog_code_i [2];
  logic [9:0] pot_wiper_i [2];
  logic [9:0] pot_low_i [2];
  logic [14:0] pd_duty_i;
  logic [4:0] driver_output_n_o;
  logic [1:0] onoff_output_n_o;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // ===================================================================
  // block and far side
  mcio_top #(.TICK_CYCLES(T)) i_mcio_top (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .switch_input_i(switch_input_i),
    .output_sense_i(output_sense_i), .analog_code_i(analog_code_i), .pot_wiper_i(pot_wiper_i),
    .pot_low_i(pot_low_i), .pd_duty_i(pd_duty_i), .driver_output_n_o(driver_output_n_o),
    .onoff_output_n_o(onoff_output_n_o), .analog_output_n_o(analog_output_n_o),
    .drive_chain_o(drive_chain_o), .stop_chain_o(stop_chain_o));
  mcio_field_model i_mcio_field_model (.sw_level_i(sw_level), .driver_n_i(driver_output_n_o),
    .onoff_n_i(onoff_output_n_o), .switch_o(switch_input_i), .sense_o(output_sense_i));
  // ===================================================================
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      test_done();
    end
  end
  // ===================================================================
  // bus cycles and compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ===================================================================
  // scenarios
  task automatic t_reset();
    rdchk(mcio_pkg::REG_ANA_CUTOFF0, mcio_pkg::CUTOFF_RST);
    rdchk(mcio_pkg::REG_DBN_CFG, 16'h0004);
    rdchk(8'hFF, 16'h0000);
    $display("t_reset end");
  endtask
  task automatic t_dbn();
    sw_level[0] <= 1'b1;
    w(14 * T);
    rd(mcio_pkg::REG_SW_STATE);
    chk({15'h0000, v[2]}, 16'h0000);
    w(3 * T);
    rd(mcio_pkg::REG_SW_STATE);
    chk({15'h0000, v[2]}, 16'h0001);
    wr(mcio_pkg::REG_DBN_CFG, 16'h0009);
    rdchk(mcio_pkg::REG_DBN_CFG, 16'h0008);
    wr(mcio_pkg::REG_DBN_CFG, 16'h0000);
    sw_level[0] <= 1'b0;
    w(4);
    rd(mcio_pkg::REG_SW_STATE);
    chk({15'h0000, v[2]}, 16'h0000);
    $display("t_dbn end");
  endtask
  task automatic t_duty();
    int n;
    wr(mcio_pkg::REG_DUTY0 + 8'h01, 16'h4000);
    rdchk(mcio_pkg::REG_DUTY_RB0 + 8'h01, 16'h4000);
    n = 0;
    repeat (mcio_pkg::PWM_PERIOD) begin
      @(posedge clk_i) #1;
      if (driver_output_n_o[1] === 1'b0) n++;
    end
    chk(16'(n), 16'h4000);
    wr(mcio_pkg::REG_DUTY0 + 8'h01, 16'h8000);
    rdchk(mcio_pkg::REG_DUTY_RB0 + 8'h01, 16'h0000);
    wr(mcio_pkg::REG_DUTY0 + 8'h05, 16'h7FFF);
    rdchk(mcio_pkg::REG_DUTY_RB0 + 8'h05, 16'h7FFF);
    wr(mcio_pkg::REG_DUTY0 + 8'h05, 16'h8000);
    w(14);
    pd_duty_i <= 15'h1234;
    wr(mcio_pkg::REG_PD_EN, 16'h0001);
    wr(mcio_pkg::REG_DUTY0 + 8'h04, 16'h0100);
    rdchk(mcio_pkg::REG_DUTY_RB0 + 8'h04, 16'h1234);
    wr(mcio_pkg::REG_PD_EN, 16'h0000);
    wr(mcio_pkg::REG_DUTY0 + 8'h04, 16'h0100);
    rdchk(mcio_pkg::REG_DUTY_RB0 + 8'h04, 16'h0100);
    $display("t_duty end");
  endtask
  task automatic t_onoff();
    wr(mcio_pkg::REG_ONOFF_SET, 16'h0001);
    rdchk(mcio_pkg::REG_ONOFF_SET, 16'h0001);
    chk({14'h0000, onoff_output_n_o}, 16'h0002);
    w(2);
    rd(mcio_pkg::REG_SW_STATE);
    chk({14'h0000, v[14:13]}, 16'h0002);
    wr(mcio_pkg::REG_ONOFF_CLR, 16'h0003);
    rdchk(mcio_pkg::REG_ONOFF_SET, 16'h0000);
    chk({14'h0000, onoff_output_n_o}, 16'h0003);
    $display("t_onoff end");
  endtask
  task automatic t_pot();
    pot_wiper_i[0] <= 10'h300;
    pot_low_i[0] <= 10'h100;
    wr(mcio_pkg::REG_POT_CFG, 16'h0050);
    wr(mcio_pkg::REG_SOFT_DRIVE, 16'h1357);
    w(2);
    chk(drive_chain_o, 16'h1357);
    rdchk(mcio_pkg::REG_POT_VAL0, 16'h4000);
    wr(mcio_pkg::REG_POT_CFG, 16'h0051);
    rdchk(mcio_pkg::REG_POT_VAL0, 16'h6000);
    wr(mcio_pkg::REG_POT_CFG, 16'h0022);
    rdchk(mcio_pkg::REG_POT_VAL0, 16'h4000);
    wr(mcio_pkg::REG_POT_SUB0, 16'h0123);
    pot_wiper_i[0] <= 10'h3F0;
    rdchk(mcio_pkg::REG_POT_VAL0, 16'h0123);
    chk(drive_chain_o, 16'h0123);
    pot_wiper_i[0] <= 10'h300;
    wr(mcio_pkg::REG_POT_CFG, 16'h0050);
    wr(mcio_pkg::REG_AUTO_SEL, 16'h0001);
    rdchk(mcio_pkg::REG_DUTY_RB0, 16'h4000);
    pot_wiper_i[0] <= 10'h200;
    w(4);
    rdchk(mcio_pkg::REG_DUTY_RB0, 16'h2000);
    $display("t_pot end");
  endtask
  task automatic t_analog();
    analog_code_i[0] <= 10'h3FF;
    w(3 * T);
    rdchk(mcio_pkg::REG_ANA_SAMPLE0, 16'h03FF);
    rd(mcio_pkg::REG_SW_STATE);
    chk({15'h0000, v[0]}, 16'h0001);
    $display("t_analog end");
  endtask
  // ===================================================================
  // main sequence
  initial begin
    resetn_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    sw_level = 7'h00;
    analog_code_i = '{10'h000, 10'h000};
    pot_wiper_i = '{10'h000, 10'h000};
    pot_low_i = '{10'h000, 10'h000};
    pd_duty_i = 15'h0000;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_dbn();
    t_duty();
    t_onoff();
    t_pot();
    t_analog();
    resetn_i <= 1'b0;
    w(2);
    resetn_i <= 1'b1;
    t_reset();
    test_done();
  end
endmodule
